// ---- verilog/asram_pkg.sv ----
package asram_pkg;
    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int ADDR_W = 18;  // Word address width
    localparam int DATA_W = 16;  // Data bus width
    localparam int LANE_W = 8;   // Byte lane width

    // ----------------------------------------
    // Timing in ns and clock rate
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 20;      // 50 MHz
    localparam int ADDR_ACCESS_NS = 12;     // Address to data valid, max
    localparam int CYCLE_NS = 12;           // Least cycle time
    localparam int SELECT_TO_WRITE_END_NS = 8;  // Write pulse, min
    localparam int DATA_SETUP_NS = 6;       // Data before write end, min
    localparam int DRIVE_RELEASE_NS = 6;    // Device float time, max
    localparam int TURN_ON_NS = 3;          // Device turn-on, min

    // Least time in cycles, rounded up, never below one
    function automatic int asram_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int READ_WAIT = asram_cycles(ADDR_ACCESS_NS);
    localparam int WRITE_WAIT = asram_cycles(SELECT_TO_WRITE_END_NS);
    localparam int FLOAT_WAIT = asram_cycles(DRIVE_RELEASE_NS);
    localparam int CNT_W = 4;  // Wait counter width

    // Reset values of the pins (all strobes inactive high)
    localparam logic STROBE_IDLE = 1'h1;

    // ----------------------------------------
    // Controller states
    // ----------------------------------------
    typedef enum logic [2:0] {
        ASRAM_IDLE, ASRAM_RD_WAIT, ASRAM_RD_DONE,
        ASRAM_WR_PULSE, ASRAM_WR_END, ASRAM_TURN
    } asram_state_t;
endpackage

// ---- verilog/asram_wait_counter.sv ----
`timescale 1ns/1ps
// Loadable down counter used to time pin phases
module asram_wait_counter
    import asram_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic load,            // Load a new count
    input wire logic [CNT_W-1:0] loadValue,
    output logic expired              // Count is zero
);
    logic [CNT_W-1:0] count;  // Remaining cycles
    logic [CNT_W-1:0] next_count;

    // ----------------------------------------
    // Next count
    // ----------------------------------------
    always_comb begin
        if (load) begin
            next_count = loadValue;
        end else if (count != '0) begin
            next_count = count - 4'h1;
        end else begin
            next_count = count;
        end
    end

    // Register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign expired = (count == '0);
endmodule

// ---- verilog/asram_host_ctrl.sv ----
`timescale 1ns/1ps
module asram_host_ctrl
    import asram_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    // User side
    input wire logic reqValid,              // Request present
    output logic reqReady,                  // Request taken this cycle
    input wire logic reqWrite,              // 1 write, 0 read
    input wire logic [ADDR_W-1:0] reqAddr,  // Word address
    input wire logic [DATA_W-1:0] reqData,  // Write data
    input wire logic [1:0] reqLanes,        // Bit0 low lane, bit1 upper
    output logic rspValid,                  // Read data pulse
    output logic [DATA_W-1:0] rspData,      // Read data
    // Memory pins
    output logic [ADDR_W-1:0] word_addr,
    output logic chip_sel_n,
    output logic out_en_n,
    output logic write_en_n,
    output logic upper_byte_sel_n,
    output logic lower_byte_sel_n,
    input wire logic [DATA_W-1:0] data_pins_in,
    output logic [DATA_W-1:0] data_pins_out,
    output logic data_pins_oe
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    asram_state_t state, next_state;  // Controller phase
    logic [ADDR_W-1:0] next_word_addr;
    logic next_chip_sel_n;
    logic next_out_en_n;
    logic next_write_en_n;
    logic next_upper_byte_sel_n;
    logic next_lower_byte_sel_n;
    logic [DATA_W-1:0] next_data_pins_out;
    logic next_data_pins_oe;
    logic [DATA_W-1:0] next_rspData;
    logic next_rspValid;
    logic [1:0] lanes;                // Lanes of current access
    logic [1:0] next_lanes;
    logic cntLoad;                    // Start a wait
    logic [CNT_W-1:0] cntValue;       // Wait length
    logic cntDone;                    // Wait over

    // Phase timer
    // One load per timed phase; expired gates leaving the read wait, write pulse and turn states
    // All waits are rounded up to whole clock periods
    asram_wait_counter u_wait (
        .clk(clk),
        .rst_b(rst_b),
        .load(cntLoad),
        .loadValue(cntValue),
        .expired(cntDone)
    );

    // ----------------------------------------
    // Request handshake
    // ----------------------------------------
    // Taken only when idle and at least one lane chosen
    // Combinational, so a waiting request goes on the first idle edge
    // A request with no lane would strobe nothing, so it is refused
    assign reqReady = (state == ASRAM_IDLE) && (reqLanes != 2'h0);

    // ----------------------------------------
    // Next values
    // ----------------------------------------
    // Defaults hold every pin; the answer strobe lasts one cycle
    // Address and data change only on the idle edge that takes a
    // request, together with the strobes' fall, and stay settled until after they rise
    always_comb begin
        next_state = state;
        next_word_addr = word_addr;
        next_chip_sel_n = chip_sel_n;
        next_out_en_n = out_en_n;
        next_write_en_n = write_en_n;
        next_upper_byte_sel_n = upper_byte_sel_n;
        next_lower_byte_sel_n = lower_byte_sel_n;
        next_data_pins_out = data_pins_out;
        next_data_pins_oe = data_pins_oe;
        next_rspData = rspData;
        next_rspValid = 1'h0;
        next_lanes = lanes;
        cntLoad = 1'h0;
        cntValue = '0;
        case (state)
            ASRAM_IDLE: begin
                // Address moves only while all strobes are high
                if (reqValid && reqReady) begin
                    next_word_addr = reqAddr;
                    next_lanes = reqLanes;
                    next_chip_sel_n = 1'h0;
                    next_lower_byte_sel_n = ~reqLanes[0];
                    next_upper_byte_sel_n = ~reqLanes[1];
                    cntLoad = 1'h1;
                    if (reqWrite) begin
                        // Strobes and data fall together; output
                        // enable stays high, device never drives
                        next_write_en_n = 1'h0;
                        next_data_pins_out = reqData;
                        next_data_pins_oe = 1'h1;
                        cntValue = CNT_W'(WRITE_WAIT);
                        next_state = ASRAM_WR_PULSE;
                    end else begin
                        next_out_en_n = 1'h0;
                        cntValue = CNT_W'(READ_WAIT);
                        next_state = ASRAM_RD_WAIT;
                    end
                end
            end
            ASRAM_RD_WAIT: begin
                // Wait out access time before sampling
                if (cntDone) begin
                    next_state = ASRAM_RD_DONE;
                end
            end
            ASRAM_RD_DONE: begin
                // Sample only the enabled lanes, zero others
                // Strobes rise together; device floats within release time
                next_rspData = data_pins_in &
                    {{LANE_W{lanes[1]}}, {LANE_W{lanes[0]}}};
                next_rspValid = 1'h1;
                next_chip_sel_n = STROBE_IDLE;
                next_out_en_n = STROBE_IDLE;
                next_upper_byte_sel_n = STROBE_IDLE;
                next_lower_byte_sel_n = STROBE_IDLE;
                cntLoad = 1'h1;
                cntValue = CNT_W'(FLOAT_WAIT);
                next_state = ASRAM_TURN;
            end
            ASRAM_WR_PULSE: begin
                // Hold strobes, address and data through the pulse
                if (cntDone) begin
                    next_state = ASRAM_WR_END;
                end
            end
            ASRAM_WR_END: begin
                // All strobes rise together; address and data kept
                // Data and drive enable stay one more cycle as hold
                next_write_en_n = STROBE_IDLE;
                next_chip_sel_n = STROBE_IDLE;
                next_upper_byte_sel_n = STROBE_IDLE;
                next_lower_byte_sel_n = STROBE_IDLE;
                cntLoad = 1'h1;
                cntValue = CNT_W'(FLOAT_WAIT);
                next_state = ASRAM_TURN;
            end
            ASRAM_TURN: begin
                // Release bus; wait until device output is floated
                // The hold-off also keeps a device turn-on away from
                // the data of a preceding write
                next_data_pins_oe = 1'h0;
                if (cntDone) begin
                    next_state = ASRAM_IDLE;
                end
            end
            default: begin
                next_state = ASRAM_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Every pin comes from a flip-flop, so strobes never glitch
    // Reset leaves all strobes inactive and the data pins released
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ASRAM_IDLE;
            word_addr <= '0;
            chip_sel_n <= STROBE_IDLE;
            out_en_n <= STROBE_IDLE;
            write_en_n <= STROBE_IDLE;
            upper_byte_sel_n <= STROBE_IDLE;
            lower_byte_sel_n <= STROBE_IDLE;
            data_pins_out <= '0;
            data_pins_oe <= 1'h0;
            rspData <= '0;
            rspValid <= 1'h0;
            lanes <= '0;
        end else begin
            state <= next_state;
            word_addr <= next_word_addr;
            chip_sel_n <= next_chip_sel_n;
            out_en_n <= next_out_en_n;
            write_en_n <= next_write_en_n;
            upper_byte_sel_n <= next_upper_byte_sel_n;
            lower_byte_sel_n <= next_lower_byte_sel_n;
            data_pins_out <= next_data_pins_out;
            data_pins_oe <= next_data_pins_oe;
            rspData <= next_rspData;
            rspValid <= next_rspValid;
            lanes <= next_lanes;
        end
    end
endmodule

// ---- tb/asram_host_ctrl_checker.sv ----
`timescale 1ns/1ps
// Pin sequencing checks on the host controller ports
module asram_host_ctrl_checker
    import asram_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire logic [1:0] reqLanes,
    input wire logic rspValid,
    input wire logic [ADDR_W-1:0] word_addr,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic write_en_n,
    input wire logic upper_byte_sel_n,
    input wire logic lower_byte_sel_n,
    input wire logic [DATA_W-1:0] data_pins_out,
    input wire logic data_pins_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_read_cycle_len: assert property ($fell(out_en_n) |->
        (!out_en_n && !chip_sel_n && write_en_n)[*3]
        ##1 (out_en_n && rspValid))
        else $error("read strobe sequence wrong");
    a_write_pulse_len: assert property ($fell(write_en_n) |->
        (!write_en_n && !chip_sel_n && out_en_n)[*3] ##1
        (write_en_n && chip_sel_n && upper_byte_sel_n && lower_byte_sel_n))
        else $error("write pulse wrong");
    a_write_data_hold: assert property ($rose(write_en_n) |->
        data_pins_oe && $stable(word_addr) && $stable(data_pins_out)
        ##1 !data_pins_oe) else $error("write hold wrong");
    a_addr_steady: assert property (
        !chip_sel_n && !$past(chip_sel_n) |-> $stable(word_addr))
        else $error("address moved in cycle");
    a_no_bus_fight: assert property (data_pins_oe |-> out_en_n)
        else $error("host drives while output enabled");
    a_write_data_on: assert property (!write_en_n |-> data_pins_oe)
        else $error("write without data");
    a_lane_chosen: assert property (!chip_sel_n |->
        !(upper_byte_sel_n && lower_byte_sel_n)) else $error("no lane");
    a_no_lane_refused: assert property (
        reqLanes == 2'h0 |-> !reqReady) else $error("empty lane request taken");
    a_busy_refused: assert property (!chip_sel_n |-> !reqReady)
        else $error("request taken while busy");
    a_answer_pulse: assert property (rspValid |=> !rspValid)
        else $error("answer longer than one cycle");
    c_read: cover property ($fell(out_en_n));
    c_write: cover property ($fell(write_en_n));
    c_refuse: cover property (reqValid && reqLanes == 2'h0);
    c_lane_read: cover property (!out_en_n && upper_byte_sel_n);
    c_lane_write: cover property (!write_en_n && lower_byte_sel_n);
endmodule

bind asram_host_ctrl asram_host_ctrl_checker asram_host_ctrl_checker_i (
    .clk, .rst_b, .reqValid, .reqReady, .reqLanes, .rspValid, .word_addr,
    .chip_sel_n, .out_en_n, .write_en_n, .upper_byte_sel_n,
    .lower_byte_sel_n, .data_pins_out, .data_pins_oe);

// ---- tb/asram_mem_model.sv ----
`timescale 1ns/1ps
// Behavioural static memory; also resolves the shared data wire
module asram_mem_model
    import asram_pkg::*;
#(
    parameter int ACC_NS = 12,  // Access delay, raise for a slow part
    parameter int HOLD_NS = 3,  // Old data kept after address change
    parameter int ON_NS = 3  // Turn-on delay after select or enable
)(
    input wire logic clk,
    input wire logic [ADDR_W-1:0] word_addr,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic write_en_n,
    input wire logic upper_byte_sel_n,
    input wire logic lower_byte_sel_n,
    input wire logic [DATA_W-1:0] data_pins_out,
    input wire logic data_pins_oe,
    output logic [DATA_W-1:0] data_pins_in
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];  // Word store
    logic [DATA_W-1:0] rdData;  // Delayed read data
    logic [DATA_W-1:0] lastBus = 16'h0;  // Wire seen last cycle
    logic [1:0] lanes;  // Selected lanes
    logic [1:0] wLanes;  // Lanes of the write in progress
    logic [1:0] drive;  // Lanes the memory drives
    logic [1:0] driveOn = 2'h0;  // Lanes past the turn-on delay
    logic writing;  // Overlap of select, write enable and at least one lane select
    assign lanes = ~{upper_byte_sel_n, lower_byte_sel_n};
    assign writing = !chip_sel_n && !write_en_n && lanes != 2'h0;
    // Drive only in read mode; any strobe leaving it floats at once
    assign drive = (!chip_sel_n && !out_en_n && write_en_n) ?
        lanes : 2'h0;
    // Lanes start driving only after the turn-on delay
    always @(drive) driveOn <= #(ON_NS) drive;
    // Old data kept for the hold time, then inverted until access time
    always @(word_addr or drive) begin
        rdData <= #(HOLD_NS) ~lastBus;
        rdData <= #(ACC_NS) mem[word_addr];
    end
    // Floating lanes flip each cycle so stale data never matches
    always @(posedge clk) lastBus <= data_pins_in;
    // Lanes captured on clock edges inside the overlap, free of races
    always @(posedge clk) if (writing) wLanes <= lanes;
    // Store the lanes at the end of the overlap
    always @(negedge writing) begin
        if (wLanes[0]) mem[word_addr][7:0] = data_pins_in[7:0];
        if (wLanes[1]) mem[word_addr][15:8] = data_pins_in[15:8];
    end
    for (genvar b = 0; b < 2; b++) begin : g_lane
        assign data_pins_in[b*8+:8] = (data_pins_oe && drive[b]) ? 8'hxx :
            data_pins_oe ? data_pins_out[b*8+:8] :
            (drive[b] && driveOn[b]) ? rdData[b*8+:8] : ~lastBus[b*8+:8];
    end
endmodule

// ---- tb/tb_async_sram_256k_x16_port.sv ----
`timescale 1ns/1ps
// Host controller against the behavioural memory
module tb_async_sram_256k_x16_port
    import asram_pkg::*;
;
    typedef struct packed {
        logic wr;
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        logic [1:0] l;
        logic [DATA_W-1:0] e;
    } asram_row_t;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic reqValid = 1'h0, reqWrite = 1'h0;
    logic [ADDR_W-1:0] reqAddr = 18'h0, word_addr;
    logic [DATA_W-1:0] reqData = 16'h0, rspData, data_pins_in, data_pins_out;
    logic [1:0] reqLanes = 2'h0;
    logic reqReady, rspValid, chip_sel_n, out_en_n, write_en_n;
    logic upper_byte_sel_n, lower_byte_sel_n, data_pins_oe;
    int failures = 0, checks = 0;
    logic [6:0] idlePins;  // Strobes, drive enable and answer
    logic [1:0] pinLanes;  // Lanes selected on the pins
    assign idlePins = {chip_sel_n, out_en_n, write_en_n, upper_byte_sel_n,
        lower_byte_sel_n, data_pins_oe, rspValid};
    assign pinLanes = ~{upper_byte_sel_n, lower_byte_sel_n};
    // Write, read back, byte lanes; expected read data in last column
    asram_row_t rows [9] = '{
        '{1'h1, 18'h00000, 16'h1234, 2'h3, 16'h0},
        '{1'h1, 18'h3ffff, 16'habcd, 2'h3, 16'h0},
        '{1'h0, 18'h00000, 16'h0, 2'h3, 16'h1234},
        '{1'h0, 18'h3ffff, 16'h0, 2'h3, 16'habcd},
        '{1'h1, 18'h3ffff, 16'h55ee, 2'h1, 16'h0},
        '{1'h1, 18'h00000, 16'h9900, 2'h2, 16'h0},
        '{1'h0, 18'h3ffff, 16'h0, 2'h3, 16'habee},
        '{1'h0, 18'h00000, 16'h0, 2'h1, 16'h0034},
        '{1'h0, 18'h00000, 16'h0, 2'h2, 16'h9900}};
    asram_host_ctrl asram_host_ctrl_i (.clk(clk), .rst_b(rst_b),
        .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite),
        .reqAddr(reqAddr), .reqData(reqData), .reqLanes(reqLanes),
        .rspValid(rspValid), .rspData(rspData), .word_addr(word_addr),
        .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
        .upper_byte_sel_n(upper_byte_sel_n),
        .lower_byte_sel_n(lower_byte_sel_n), .data_pins_in(data_pins_in),
        .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe));
    asram_mem_model asram_mem_model_i (.clk(clk), .word_addr(word_addr),
        .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
        .upper_byte_sel_n(upper_byte_sel_n),
        .lower_byte_sel_n(lower_byte_sel_n), .data_pins_out(data_pins_out),
        .data_pins_oe(data_pins_oe), .data_pins_in(data_pins_in));
    always #(CLK_PERIOD_NS / 2) clk = ~clk;
    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One request, held until taken; reads wait for the answer
    task automatic run(input asram_row_t r);
        int n;
        @(negedge clk);
        {reqValid, reqWrite, reqAddr} = {1'h1, r.wr, r.a};
        {reqData, reqLanes} = {r.d, r.l};
        for (n = 0; n < 20 && reqReady !== 1'h1; n++) @(negedge clk);
        check("ready", 32'h1, 32'(reqReady));
        @(negedge clk);
        reqValid = 1'h0;
        for (n = 0; n < 4 && chip_sel_n !== 1'h0; n++) @(negedge clk);
        check("select", 32'h0, 32'(chip_sel_n));
        check("address", 32'(r.a), 32'(word_addr));
        check("lanes", 32'(r.l), 32'(pinLanes));
        if (!r.wr) begin
            // Answer stands one cycle, three cycles after strobes fall
            for (n = 0; n < 10 && rspValid !== 1'h1; n++) @(negedge clk);
            check("answer", 32'h1, 32'(rspValid));
            check("answer cycles", 32'h3, 32'(n));
            check("read data", 32'(r.e), 32'(rspData));
        end
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        check("reset pins", 32'h7c, 32'(idlePins));
        rst_b = 1'h1;
        foreach (rows[i]) run(rows[i]);
        // Request with no lane must be refused
        @(negedge clk);
        {reqValid, reqWrite, reqLanes} = {1'h1, 1'h1, 2'h0};
        repeat (3) @(negedge clk);
        check("refused", 32'h1, 32'({~reqReady & chip_sel_n}));
        reqValid = 1'h0;
        // Reset in mid read, then a clean read after it
        @(negedge clk);
        {reqValid, reqWrite, reqAddr, reqLanes} = {1'h1, 1'h0, 18'h0, 2'h3};
        repeat (2) @(negedge clk);
        {rst_b, reqValid} = 2'h0;
        @(negedge clk);
        check("mid reset", 32'h7c, 32'(idlePins));
        rst_b = 1'h1;
        @(negedge clk);
        check("after reset", 32'h7c, 32'(idlePins));
        run(rows[6]);
        finish_test();
    end
    initial begin
        #100us;
        failures++;
        finish_test();
    end
endmodule
